// ### common/edge_if.sv
// Edge strobes passed from the edge detector to the trigger logic
`timescale 1ns/10ps
interface edge_if #(parameter int N = 23);
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : edge_if

// ### common/line_trig_pkg.sv
// Constants for the line edge trigger and pending block
package line_trig_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_LINES = 23;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RISE_SEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FALL_SEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SOFT_TRIG = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PENDING   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 8'h1C;

  // ==========================================================================
  // Implemented lines: 22..19 and 17..0, line 18 absent
  localparam logic [NUM_LINES-1:0] LINE_IMPL = 23'h7BFFFF;

  // ==========================================================================
  // Reset values
  localparam logic [NUM_LINES-1:0] RST_INT_MASK  = 23'h000000;
  localparam logic [NUM_LINES-1:0] RST_EVT_MASK  = 23'h000000;
  localparam logic [NUM_LINES-1:0] RST_RISE_SEL  = 23'h000000;
  localparam logic [NUM_LINES-1:0] RST_FALL_SEL  = 23'h000000;
  localparam logic [NUM_LINES-1:0] RST_SOFT_TRIG = 23'h000000;
  localparam logic [NUM_LINES-1:0] RST_PENDING   = 23'h000000;

  // ==========================================================================
  // Block interrupt status fields
  localparam int ST_W        = 3;
  localparam int ST_PEND_SET = 0;
  localparam int ST_EVENT    = 1;
  localparam int ST_SOFT     = 2;
  localparam logic [ST_W-1:0] RST_IRQ = 3'h0;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] FULL_STRB   = 4'hF;

endpackage : line_trig_pkg

// ### core/edge_detect.sv
// Line synchroniser and edge strobe generator
`timescale 1ns/10ps
module edge_detect #(
  parameter int N = 23
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw lines
  input  wire logic [N-1:0] line_in,
  // Strobes
  edge_if.src               edges
);

  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= line_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // One-cycle strobes from sample comparison
  assign edges.rise = sync2 & ~prev; // [R16]
  assign edges.fall = ~sync2 & prev; // [R16]

endmodule : edge_detect

// ### core/line_edge_trigger_pending.sv
// Per-line edge trigger, software trigger and pending logic with AXI4-Lite
// Functional notes
// R1: rising select enables rising-edge trigger
// R2: falling select enables falling-edge trigger
// R3: both selects set: either edge triggers
// R4: software writes reserved bits as zero
// R5: rising edge during rising-select write ignored
// R6: falling edge during falling-select write ignored
// R7: line sources must be glitch free
// R8: new soft trigger with mask sets pending
// R9: soft trigger clears with its pending flag
// R10: enabled edge sets the pending flag
// R11: pending flags clear on writing one
// R12: selects and soft trigger reset to zero
// R13: line request only when mask bit set
// R14: event-only line pulses, pending untouched
// R15: software uses full word accesses only
// R16: synchronise lines, compare samples for strobes
`timescale 1ns/10ps
module line_edge_trigger_pending (
  // Clock and reset
  input  wire logic                                    aclk,
  input  wire logic                                    aresetn,
  // AXI4-Lite write address
  input  wire logic                                    s_axi_awvalid,
  output wire logic                                    s_axi_awready,
  input  wire logic [line_trig_pkg::ADDR_W-1:0]        s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                                    s_axi_wvalid,
  output wire logic                                    s_axi_wready,
  input  wire logic [line_trig_pkg::DATA_W-1:0]        s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  output logic      [1:0]                              s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                                    s_axi_arvalid,
  output wire logic                                    s_axi_arready,
  input  wire logic [line_trig_pkg::ADDR_W-1:0]        s_axi_araddr,
  // AXI4-Lite read data
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  output logic      [line_trig_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic      [1:0]                              s_axi_rresp,
  // Lines and requests
  input  wire logic [line_trig_pkg::NUM_LINES-1:0]     line_in,
  output wire logic [line_trig_pkg::NUM_LINES-1:0]     line_irq,
  output logic      [line_trig_pkg::NUM_LINES-1:0]     event_pulse,
  // Block interrupt
  output wire logic                                    irq
);
  import line_trig_pkg::*;

  // ==========================================================================
  // Storage
  logic [NUM_LINES-1:0] interrupt_mask_reg;
  logic [NUM_LINES-1:0] event_mask_reg;
  logic [NUM_LINES-1:0] rising_edge_select;
  logic [NUM_LINES-1:0] falling_edge_select;
  logic [NUM_LINES-1:0] software_trigger;
  logic [NUM_LINES-1:0] pending_flags;
  logic [ST_W-1:0]      irq_status;
  logic [ST_W-1:0]      irq_enable;

  // Bus holding state
  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    aw_addr_q;
  logic [DATA_W-1:0]    w_data_q;
  logic [3:0]           w_strb_q;

  // Decoded write and read
  logic                 aw_fire;
  logic                 w_fire;
  logic                 ar_fire;
  logic                 wr_en;
  logic                 wr_ok;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [3:0]           wr_strb;
  logic [NUM_LINES-1:0] wr_lines;
  logic                 wr_imask;
  logic                 wr_emask;
  logic                 wr_rise;
  logic                 wr_fall;
  logic                 wr_soft;
  logic                 wr_pend;
  logic                 wr_irq_en;
  logic                 rd_stat;
  logic [DATA_W-1:0]    rd_word;
  logic                 rd_hit;

  // Trigger terms
  logic [NUM_LINES-1:0] rise_set;
  logic [NUM_LINES-1:0] fall_set;
  logic [NUM_LINES-1:0] hw_trig;
  logic [NUM_LINES-1:0] soft_new;
  logic [NUM_LINES-1:0] ev_only;
  logic [NUM_LINES-1:0] pend_set;
  logic [NUM_LINES-1:0] pend_clr;
  logic [NUM_LINES-1:0] evt_hit;
  logic [ST_W-1:0]      st_events;

  // ==========================================================================
  // Edge detection
  edge_if #(.N(NUM_LINES)) edges ();

  edge_detect #(.N(NUM_LINES)) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line_in (line_in),
    .edges   (edges.src)
  );

  // ==========================================================================
  // Write channel acceptance
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;

  // Address and data taken now or earlier
  assign wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data  = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
  assign wr_en    = (aw_held || aw_fire) && (w_held || w_fire);

  // Partial words and unmapped offsets are refused
  assign wr_ok    = wr_en && (wr_strb == FULL_STRB) && (wr_addr[1:0] == 2'h0)
                    && (wr_addr <= OFF_IRQ_EN); // [R15]
  assign wr_lines = wr_data[NUM_LINES-1:0] & LINE_IMPL; // [R4]

  // Per-register write strobes
  assign wr_imask  = wr_ok && (wr_addr == OFF_INT_MASK);
  assign wr_emask  = wr_ok && (wr_addr == OFF_EVT_MASK);
  assign wr_rise   = wr_ok && (wr_addr == OFF_RISE_SEL);
  assign wr_fall   = wr_ok && (wr_addr == OFF_FALL_SEL);
  assign wr_soft   = wr_ok && (wr_addr == OFF_SOFT_TRIG);
  assign wr_pend   = wr_ok && (wr_addr == OFF_PENDING);
  assign wr_irq_en = wr_ok && (wr_addr == OFF_IRQ_EN);

  // Hold address or data until its partner arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
    end else if (wr_en) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response one edge after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_stat       = ar_fire && (s_axi_araddr == OFF_IRQ_STAT);

  // Read multiplexer, upper bits read zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      OFF_INT_MASK:  rd_word[NUM_LINES-1:0] = interrupt_mask_reg;
      OFF_EVT_MASK:  rd_word[NUM_LINES-1:0] = event_mask_reg;
      OFF_RISE_SEL:  rd_word[NUM_LINES-1:0] = rising_edge_select;
      OFF_FALL_SEL:  rd_word[NUM_LINES-1:0] = falling_edge_select;
      OFF_SOFT_TRIG: rd_word[NUM_LINES-1:0] = software_trigger;
      OFF_PENDING:   rd_word[NUM_LINES-1:0] = pending_flags; // [R11]
      OFF_IRQ_STAT:  rd_word[ST_W-1:0]      = irq_status;
      OFF_IRQ_EN:    rd_word[ST_W-1:0]      = irq_enable;
      default:       rd_hit                 = 1'b0;
    endcase
  end

  // Read data registered on address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_mask_reg  <= RST_INT_MASK;
      event_mask_reg      <= RST_EVT_MASK;
      rising_edge_select  <= RST_RISE_SEL; // [R12]
      falling_edge_select <= RST_FALL_SEL; // [R12]
      irq_enable          <= RST_IRQ;
    end else begin
      if (wr_imask)
        interrupt_mask_reg <= wr_lines;
      if (wr_emask)
        event_mask_reg <= wr_lines;
      if (wr_rise)
        rising_edge_select <= wr_lines;
      if (wr_fall)
        falling_edge_select <= wr_lines;
      if (wr_irq_en)
        irq_enable <= wr_data[ST_W-1:0];
    end
  end

  // ==========================================================================
  // Trigger qualification
  assign rise_set = edges.rise & rising_edge_select & {NUM_LINES{!wr_rise}};  // [R1] [R5]
  assign fall_set = edges.fall & falling_edge_select & {NUM_LINES{!wr_fall}}; // [R2] [R6]
  assign hw_trig  = rise_set | fall_set; // [R3]

  // Only a zero-to-one change of a soft trigger bit counts
  assign soft_new = wr_soft ? (wr_lines & ~software_trigger) : '0;

  // Event-only lines never raise their pending flag
  assign ev_only  = event_mask_reg & ~interrupt_mask_reg;
  assign pend_set = (hw_trig & ~ev_only) | (soft_new & interrupt_mask_reg); // [R10] [R8]
  assign pend_clr = wr_pend ? wr_lines : '0; // [R11]
  assign evt_hit  = (hw_trig | soft_new) & event_mask_reg;

  // Pending flags, a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pending_flags <= RST_PENDING;
    else
      pending_flags <= (pending_flags & ~pend_clr) | pend_set; // [R10] [R11]
  end

  // Soft trigger bits live until their pending flag is cleared
  always_ff @(posedge aclk) begin
    if (!aresetn)
      software_trigger <= RST_SOFT_TRIG; // [R12]
    else
      software_trigger <= (software_trigger & ~pend_clr) | soft_new; // [R9]
  end

  // One-cycle event pulse per enabled edge
  always_ff @(posedge aclk) begin
    if (!aresetn)
      event_pulse <= '0;
    else
      event_pulse <= evt_hit; // [R14]
  end

  // Per-line request gated by the interrupt mask
  assign line_irq = pending_flags & interrupt_mask_reg; // [R13]

  // ==========================================================================
  // Block interrupt, sticky status cleared by reading it
  assign st_events[ST_PEND_SET] = |pend_set;
  assign st_events[ST_EVENT]    = |evt_hit;
  assign st_events[ST_SOFT]     = |soft_new;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_status <= RST_IRQ;
    else
      irq_status <= (rd_stat ? RST_IRQ : irq_status) | st_events;
  end

  assign irq = |(irq_status & irq_enable);

  // ==========================================================================
  // Checks
  property p_rise_pend;
    @(posedge aclk) disable iff (!aresetn)
    (rise_set & ~ev_only) != '0 |=> (pending_flags & $past(rise_set & ~ev_only)) == $past(rise_set & ~ev_only);
  endproperty
  a_rise_pend: assert property (p_rise_pend) else $error("rising edge did not set pending"); // [R1]

  property p_fall_pend;
    @(posedge aclk) disable iff (!aresetn)
    ((edges.fall & falling_edge_select & ~ev_only) != '0) && !wr_fall && !wr_pend
      |=> (pending_flags & $past(fall_set & ~ev_only)) == $past(fall_set & ~ev_only);
  endproperty
  a_fall_pend: assert property (p_fall_pend) else $error("falling edge did not set pending"); // [R2]

  property p_rise_block;
    @(posedge aclk) disable iff (!aresetn)
    wr_rise && (edges.rise != '0) && (edges.fall == '0) && !$past(wr_soft)
      |=> (pending_flags & ~$past(pending_flags)) == '0;
  endproperty
  a_rise_block: assert property (p_rise_block) else $error("edge during select write set pending"); // [R5]

  property p_fall_block;
    @(posedge aclk) disable iff (!aresetn)
    wr_fall |-> (fall_set == '0) && (rise_set == (edges.rise & rising_edge_select));
  endproperty
  a_fall_block: assert property (p_fall_block) else $error("falling edge not blocked on write"); // [R6]

  property p_soft_set;
    @(posedge aclk) disable iff (!aresetn)
    (soft_new & interrupt_mask_reg) != '0
      |=> ((line_irq & $past(soft_new & interrupt_mask_reg)) == $past(soft_new & interrupt_mask_reg))
          && irq_status[ST_SOFT];
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft trigger did not raise request"); // [R8]

  property p_soft_clear;
    @(posedge aclk) disable iff (!aresetn)
    pend_clr != '0 |=> (software_trigger & $past(pend_clr)) == '0;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft trigger survived pending clear"); // [R9]

  property p_mask_gate;
    @(posedge aclk) disable iff (!aresetn)
    (line_irq & ~interrupt_mask_reg) == '0;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request on a masked line"); // [R13]

  property p_event_only;
    @(posedge aclk) disable iff (!aresetn)
    (hw_trig & ev_only) != '0 && !wr_imask && !wr_emask
      |=> ((event_pulse & $past(hw_trig & ev_only)) == $past(hw_trig & ev_only))
          && ((pending_flags & ~$past(pending_flags) & $past(hw_trig & ev_only)) == '0);
  endproperty
  a_event_only: assert property (p_event_only) else $error("event-only line misbehaved"); // [R14]

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    wr_en |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_ok) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing or wrong");

endmodule : line_edge_trigger_pending

// ### test/line_source_model.sv
// Far-side model: glitch-free wakeup line sources
`timescale 1ns/10ps
module line_source_model (
  // Clock
  input  wire logic                                aclk,
  // Lines towards the block
  output logic      [line_trig_pkg::NUM_LINES-1:0] line_in
);
  import line_trig_pkg::*;

  // ======================================
  // Edge counter for spacing changes
  int unsigned cyc;
  int unsigned last;

  // Lines start low, counter starts at zero
  initial begin
    line_in = '0;
    cyc     = 0;
    last    = 0;
  end

  // Free-running count of clock edges
  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  // One clean step on one line, at least three edges after the previous one
  task automatic set_line(input int n, input logic v);
    while (cyc - last < 3) @(posedge aclk);
    @(posedge aclk);
    line_in[n] <= v;
    last = cyc;
  endtask : set_line

endmodule : line_source_model

// ### test/testbench.sv
// Self-checking bench for the line edge trigger and pending block
`timescale 1ns/10ps
module testbench;
  import line_trig_pkg::*;

  // ======================================
  // Signals
  logic                 aclk;
  logic                 aresetn;
  logic                 s_axi_awvalid;
  logic                 s_axi_awready;
  logic [ADDR_W-1:0]    s_axi_awaddr;
  logic                 s_axi_wvalid;
  logic                 s_axi_wready;
  logic [DATA_W-1:0]    s_axi_wdata;
  logic [3:0]           s_axi_wstrb;
  logic                 s_axi_bvalid;
  logic                 s_axi_bready;
  logic [1:0]           s_axi_bresp;
  logic                 s_axi_arvalid;
  logic                 s_axi_arready;
  logic [ADDR_W-1:0]    s_axi_araddr;
  logic                 s_axi_rvalid;
  logic                 s_axi_rready;
  logic [DATA_W-1:0]    s_axi_rdata;
  logic [1:0]           s_axi_rresp;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_LINES-1:0] line_irq;
  logic [NUM_LINES-1:0] event_pulse;
  logic                 irq;
  int                   fails;
  int                   total_checks;
  int                   ev_cnt;

  // ======================================
  // Block and far side
  line_edge_trigger_pending line_edge_trigger_pending_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .line_in, .line_irq, .event_pulse, .irq
  );
  line_source_model line_source_model_i (
    .aclk,
    .line_in
  );

  // Clock at 40 MHz
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count cycles with an event pulse on line 2
  always @(posedge aclk) begin
    if (event_pulse[2] === 1'b1) ev_cnt <= ev_cnt + 1;
  end

  // ======================================
  // Compare, verdict and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : bus_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, FULL_STRB, r);
    chk($sformatf("bresp %h", a), {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(a, d, r);
    chk($sformatf("rdata %h", a), exp, d);
    chk($sformatf("rresp %h", a), {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : rd_chk

  // ======================================
  // Scenarios
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(i * 4), 32'h0);
    end
    bus_rd(8'h20, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    bus_wr(OFF_RISE_SEL, 32'h1, 4'h1, r);
    chk("partial bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_chk(OFF_RISE_SEL, 32'h0);
  endtask : test_reset

  // One line step, then pending read, line request, clear by one
  task automatic edge_case(input int n, input logic v, input logic [31:0] exp);
    line_source_model_i.set_line(n, v);
    repeat (4) @(posedge aclk);
    wr(OFF_PENDING, 32'h0);
    rd_chk(OFF_PENDING, exp);
    chk("line_irq", exp, {9'h0, line_irq});
    wr(OFF_PENDING, exp);
    rd_chk(OFF_PENDING, 32'h0);
  endtask : edge_case

  // Line step landing in the same edge as a select write
  task automatic race_case(input int n, input logic v, input logic [7:0] a, input logic [31:0] d);
    line_source_model_i.set_line(n, v);
    // Write taken at the edge that samples the strobe
    repeat (1) @(posedge aclk);
    wr(a, d);
    repeat (3) @(posedge aclk);
    rd_chk(OFF_PENDING, 32'h0);
  endtask : race_case

  task automatic test_soft;
    wr(OFF_SOFT_TRIG, 32'h80);
    rd_chk(OFF_PENDING, 32'h80);
    chk("soft line_irq", 32'h80, {9'h0, line_irq});
    wr(OFF_SOFT_TRIG, 32'h200);
    chk("unmasked line_irq", 32'h80, {9'h0, line_irq});
    rd_chk(OFF_SOFT_TRIG, 32'h280);
    rd_chk(OFF_PENDING, 32'h80);
    wr(OFF_PENDING, 32'h280);
    rd_chk(OFF_SOFT_TRIG, 32'h0);
    rd_chk(OFF_PENDING, 32'h0);
  endtask : test_soft

  task automatic test_event;
    int c;
    c = ev_cnt;
    line_source_model_i.set_line(2, 1'b1);
    repeat (6) @(posedge aclk);
    chk("event count", 32'd1, 32'(ev_cnt - c));
    rd_chk(OFF_PENDING, 32'h0);
  endtask : test_event

  task automatic test_irq;
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_IRQ_EN, 32'h1);
    bus_rd(OFF_IRQ_STAT, d, r);
    wr(OFF_SOFT_TRIG, 32'h8);
    rd_chk(OFF_PENDING, 32'h8);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_EN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_EN, 32'h1);
    chk("irq again", 32'h1, {31'h0, irq});
    rd_chk(OFF_IRQ_STAT, 32'h5);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OFF_PENDING, 32'h8);
  endtask : test_irq

  // ======================================
  // Main sequence
  initial begin
    fails         = 0;
    total_checks  = 0;
    ev_cnt        = 0;
    aresetn       = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr  = '0;
    s_axi_wvalid  = 1'b0;
    s_axi_wdata   = '0;
    s_axi_wstrb   = 4'h0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = '0;
    s_axi_rready  = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset;
    $display("reset test done");
    wr(OFF_INT_MASK, 32'h0800A8);
    wr(OFF_EVT_MASK, 32'h000004);
    wr(OFF_RISE_SEL, 32'h08000C);
    wr(OFF_FALL_SEL, 32'h080020);
    edge_case(3, 1'b1, 32'h8);
    edge_case(3, 1'b0, 32'h0);
    edge_case(5, 1'b1, 32'h0);
    edge_case(5, 1'b0, 32'h20);
    edge_case(19, 1'b1, 32'h80000);
    edge_case(19, 1'b0, 32'h80000);
    $display("edge test done");
    race_case(3, 1'b1, OFF_RISE_SEL, 32'h08000C);
    line_source_model_i.set_line(5, 1'b1);
    race_case(5, 1'b0, OFF_FALL_SEL, 32'h080020);
    $display("race test done");
    test_soft;
    $display("soft trigger test done");
    test_event;
    $display("event test done");
    test_irq;
    $display("interrupt test done");
    wrap_up;
  end

  // Hang guard, well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    wrap_up;
  end

endmodule : testbench
